/* File: rtl/vmad_decode.sv */
/*
 * video memory organisation, window placement and system address decode.
 * assumes cpu bus pins come from another domain and are synchronised here.
 */
`timescale 1ns/1ps
`include "vmad_params.svh"
module vmad_decode (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input vmad_pkg::vmad_cpu_t cpu_i,
    input vmad_pkg::vmad_mode_t mode_i,
    input wire logic [3:0] mem_cfg_i,
    input wire logic [2:0] display_page_sel_i,
    input wire logic [1:0] row_scan_addr_i,
    input wire logic [13:0] char_addr_i,
    output vmad_pkg::vmad_org_t org_o,
    output logic [17:0] video_addr_o,
    output logic [2:0] periph_sel_o,
    output logic board_buffer_enable_n_o
);
    import vmad_pkg::*;

    ////////////////////////////////////////////////////////////////
    // two-stage pin synchronisers; stage one feeds stage two only
    vmad_cpu_t cpu_s1_reg, cpu_s2_reg;
    always_ff @(posedge ref_clk_i) begin
        cpu_s1_reg <= cpu_i;
        cpu_s2_reg <= cpu_s1_reg;
    end

    ////////////////////////////////////////////////////////////////
    // mode organisation from ext bit and mode bits
    vmad_org_t org_next, org_reg;
    logic [17:0] vaddr_next, vaddr_reg;
    logic lo_eff;
    always_comb begin
        lo_eff = mode_i.video_addr_mode_lo | mode_i.graphics_select;
        case ({mode_i.extended_video_addr, mode_i.video_addr_mode_hi, lo_eff})
            3'h0: org_next = VMAD_ORG_16K_8P;
            3'h1: org_next = VMAD_ORG_2X8K_8P;
            3'h2: org_next = VMAD_ORG_2X16K_4P;
            3'h3: org_next = VMAD_ORG_4X8K_4P;
            3'h4: org_next = VMAD_ORG_32K_4P;
            3'h5: org_next = VMAD_ORG_2X32K_2P;
            default: org_next = VMAD_ORG_32K_4P; // undocumented combos: keep 32K view
        endcase
        // page bits on top, row bits pick segment, char address below
        case (org_next)
            VMAD_ORG_16K_8P: vaddr_next = {1'b0, display_page_sel_i, char_addr_i};
            VMAD_ORG_2X8K_8P: vaddr_next = {1'b0, display_page_sel_i,
                row_scan_addr_i[0], char_addr_i[12:0]};
            VMAD_ORG_2X16K_4P: vaddr_next = {display_page_sel_i[2:1],
                row_scan_addr_i[0], char_addr_i[13:0], 1'b0};
            VMAD_ORG_4X8K_4P: vaddr_next = {display_page_sel_i[2:1],
                row_scan_addr_i, char_addr_i[12:0], 1'b0};
            VMAD_ORG_32K_4P: vaddr_next = {1'b0, display_page_sel_i[2:1],
                char_addr_i, 1'b0};
            VMAD_ORG_2X32K_2P: vaddr_next = {display_page_sel_i[2],
                row_scan_addr_i[0], char_addr_i, 2'h0};
            default: vaddr_next = 18'h00000;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // window hit: function, used only for the buffer enable
    function automatic logic in_window(input logic [3:0] cfg, input logic [19:0] a);
        logic [2:0] code;
        logic [3:0] blk;
        code = cfg[2:0];
        blk = {1'b0, a[19:17]};
        in_window = 1'b0;
        if (!cfg[`VMAD_CFG_WIDE_BIT]) begin
            if (code <= 3'h4) in_window = (blk == {1'b0, code});
        end else if (code >= 3'h1 && code <= 3'h4) begin
            in_window = (blk == {1'b0, code} - 4'h1) || (blk == {1'b0, code});
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // peripheral select and buffer enable from synchronised bus
    logic [2:0] sel_next, sel_reg;
    logic buf_n_next, buf_n_reg;
    logic io_cyc, mem_cyc;
    logic [12:0] io8;
    always_comb begin
        io8 = cpu_s2_reg.addr[15:3];
        io_cyc = !cpu_s2_reg.mem_io_qualifier &&
            (!cpu_s2_reg.io_rd_n || !cpu_s2_reg.io_wr_n);
        mem_cyc = cpu_s2_reg.mem_io_qualifier &&
            (!cpu_s2_reg.mem_rd_n || !cpu_s2_reg.mem_wr_n);
        sel_next = `VMAD_SEL_NONE;
        if (io_cyc) begin
            case (io8)
                `VMAD_IO_IRQ: sel_next = `VMAD_SEL_IRQ;
                `VMAD_IO_TMR: sel_next = `VMAD_SEL_TMR;
                `VMAD_IO_PIO: sel_next = `VMAD_SEL_PIO;
                `VMAD_IO_JOY: sel_next = `VMAD_SEL_JOY;
                `VMAD_IO_SND: sel_next = `VMAD_SEL_SND;
                `VMAD_IO_FDC: sel_next = `VMAD_SEL_FDC;
                `VMAD_IO_PRN: sel_next = `VMAD_SEL_PRN;
                default: sel_next = `VMAD_SEL_NONE;
            endcase
        end
        buf_n_next = 1'b1;
        if (mem_cyc && in_window(mem_cfg_i, cpu_s2_reg.addr)) buf_n_next = 1'b0;
        if (mem_cyc && cpu_s2_reg.addr[19:15] == `VMAD_MEM_VID) buf_n_next = 1'b0;
        if (mem_cyc && cpu_s2_reg.addr[19:16] == `VMAD_MEM_ROM) buf_n_next = 1'b0;
        if (io_cyc && cpu_s2_reg.addr[15:4] == `VMAD_IO_VID) buf_n_next = 1'b0;
        if (io_cyc && (io8 == `VMAD_IO_TMR || io8 == `VMAD_IO_PIO ||
            io8 == `VMAD_IO_NMI || io8 == `VMAD_IO_SND || io8 == `VMAD_IO_JOY ||
            io8 == `VMAD_IO_PRN || io8 == `VMAD_IO_FDC)) buf_n_next = 1'b0;
    end

    // output registers; reset leaves everything idle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sel_reg <= `VMAD_SEL_NONE;
            buf_n_reg <= 1'b1;
            org_reg <= VMAD_ORG_16K_8P;
            vaddr_reg <= 18'h00000;
        end else begin
            sel_reg <= sel_next;
            buf_n_reg <= buf_n_next;
            org_reg <= org_next;
            vaddr_reg <= vaddr_next;
        end
    end

    assign periph_sel_o = sel_reg;
    assign board_buffer_enable_n_o = buf_n_reg;
    assign org_o = org_reg;
    assign video_addr_o = vaddr_reg;

    ////////////////////////////////////////////////////////////////
    // select checks; outputs lag the synchronised bus by one edge
    idle_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(io_cyc)
        |-> periph_sel_o == `VMAD_SEL_NONE)
        else $error("select active without i/o cycle");

    irq_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h004
        |-> periph_sel_o == 3'h6)
        else $error("irq select code wrong");

    tmr_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h008
        |-> periph_sel_o == 3'h5)
        else $error("timer select code wrong");

    pio_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h00C
        |-> periph_sel_o == 3'h4)
        else $error("parallel select code wrong");

    joy_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h040
        |-> periph_sel_o == 3'h3)
        else $error("joystick select code wrong");

    snd_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h018
        |-> periph_sel_o == 3'h2)
        else $error("sound select code wrong");

    fdc_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h07E
        |-> periph_sel_o == 3'h1)
        else $error("floppy select code wrong");

    prn_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h06F
        |-> periph_sel_o == 3'h0)
        else $error("printer select code wrong");

    ////////////////////////////////////////////////////////////////
    // buffer enable checks; memory and i/o decodes kept apart
    rom_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(mem_cyc) && $past(cpu_s2_reg.addr[19:16]) == 4'hF
        |-> !board_buffer_enable_n_o)
        else $error("rom access missed buffer");

    aperture_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(mem_cyc) && $past(cpu_s2_reg.addr[19:15]) == 5'h17
        |-> !board_buffer_enable_n_o)
        else $error("video aperture missed buffer");

    vid_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(cpu_s2_reg.addr[15:4]) == 12'h03D
        |-> !board_buffer_enable_n_o)
        else $error("video port missed buffer");

    idle_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(io_cyc) && !$past(mem_cyc)
        |-> board_buffer_enable_n_o)
        else $error("buffer enabled without access");

    nmi_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h014
        |-> !board_buffer_enable_n_o)
        else $error("mask port missed buffer");

    tmr_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h008
        |-> !board_buffer_enable_n_o)
        else $error("timer port missed buffer");

    pio_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h00C
        |-> !board_buffer_enable_n_o)
        else $error("parallel port missed buffer");

    joy_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h040
        |-> !board_buffer_enable_n_o)
        else $error("joystick port missed buffer");

    snd_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h018
        |-> !board_buffer_enable_n_o)
        else $error("sound port missed buffer");

    prn_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h06F
        |-> !board_buffer_enable_n_o)
        else $error("printer port missed buffer");

    fdc_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(io_cyc) && $past(io8) == 13'h07E
        |-> !board_buffer_enable_n_o)
        else $error("floppy port missed buffer");

    ////////////////////////////////////////////////////////////////
    // window and reset checks; windows only in low blocks, clear of aperture and rom
    win_buf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(mem_cyc) && $past(mem_cfg_i) == 4'h0 && $past(cpu_s2_reg.addr[19:17]) == 3'h0
        |-> !board_buffer_enable_n_o)
        else $error("window access missed buffer");

    wide_win_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(mem_cyc) && $past(mem_cfg_i) == 4'h9 && $past(cpu_s2_reg.addr[19:18]) == 2'h0
        |-> !board_buffer_enable_n_o)
        else $error("wide window access missed buffer");

    no_win_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(mem_cyc) && $past(mem_cfg_i) == 4'h8 && $past(cpu_s2_reg.addr[19:17]) == 3'h0
        |-> board_buffer_enable_n_o)
        else $error("unlisted config opened a window");

    reset_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i)
        |-> periph_sel_o == 3'h7 && board_buffer_enable_n_o)
        else $error("outputs not idle after reset");

    ////////////////////////////////////////////////////////////////
    // organisation checks; mode inputs land one edge later
    graph_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(mode_i.extended_video_addr) && !$past(mode_i.video_addr_mode_hi)
        && $past(mode_i.graphics_select) |-> org_o == VMAD_ORG_2X8K_8P)
        else $error("graphics bit did not force mode");

    base_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past({mode_i.extended_video_addr, mode_i.video_addr_mode_hi,
        mode_i.video_addr_mode_lo, mode_i.graphics_select}) == 4'h0
        |-> org_o == VMAD_ORG_16K_8P)
        else $error("base mode wrong");

    ext_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past({mode_i.extended_video_addr, mode_i.video_addr_mode_hi,
        mode_i.video_addr_mode_lo, mode_i.graphics_select}) == 4'h8
        |-> org_o == VMAD_ORG_32K_4P)
        else $error("extended mode wrong");

    ext_two_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past({mode_i.extended_video_addr, mode_i.video_addr_mode_hi,
        mode_i.video_addr_mode_lo}) == 3'h5
        |-> org_o == VMAD_ORG_2X32K_2P)
        else $error("extended two-segment mode wrong");

    quad_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past({mode_i.extended_video_addr, mode_i.video_addr_mode_hi,
        mode_i.video_addr_mode_lo}) == 3'h3
        |-> org_o == VMAD_ORG_4X8K_4P)
        else $error("four-segment mode wrong");

    ////////////////////////////////////////////////////////////////
    // address packing checks; page and row fields per organisation
    page_eight_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        org_o == VMAD_ORG_16K_8P
        |-> video_addr_o[16:14] == $past(display_page_sel_i))
        else $error("eight-page field wrong");

    char_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        org_o == VMAD_ORG_16K_8P
        |-> video_addr_o[13:0] == $past(char_addr_i))
        else $error("character address field wrong");

    seg_row_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        org_o == VMAD_ORG_2X8K_8P
        |-> video_addr_o[13] == $past(row_scan_addr_i[0]))
        else $error("row segment bit wrong");

    wide_page_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        org_o == VMAD_ORG_32K_4P
        |-> video_addr_o[16:15] == $past(display_page_sel_i[2:1]))
        else $error("wide page field wrong");

    page_top_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        org_o == VMAD_ORG_2X32K_2P
        |-> video_addr_o[17] == $past(display_page_sel_i[2]))
        else $error("two-page field wrong");
endmodule

/* File: rtl/vmad_params.svh */
/*
 * constants for the video memory map and address decode block.
 * assumes a 20-bit cpu address and 16-bit i/o decode on the low bits.
 */
// Contract
// - mode chosen from nine control bits of four registers.
// - four-bit config places 128K or 256K video/system window.
// - ext clear, modes 00: one 16K segment, eight pages.
// - ext clear, mode 01: two 8K segments on row bit 0, eight pages.
// - ext clear, mode 10: two 16K segments on row bit 0, four pages.
// - ext clear, mode 11: four 8K segments on row bits 1:0, four pages.
// - ext set, mode 00: one 32K segment, four pages.
// - ext set, mode 01: two 32K segments on row bit 0, two pages.
// - page from bits 2:0, 2:1 or 2 by page count.
// - select code 111 idle; 110 irq, 101 timer, 100 parallel.
// - select 011 joystick, 010 sound, 001 floppy, 000 printer.
// - buffer enable active low, high unless a listed access.
// - buffer enable on memory access inside configured window.
// - buffer enable on memory access B8000-BFFFF.
// - buffer enable on memory access F0000-FFFFF.
// - buffer enable on i/o access 03D0-03DF.
// - buffer enable on seven listed peripheral i/o ranges.
// - page bits select 16K page; 32K modes ignore bit 0.
// - graphics bit forces the same addressing as low mode bit.
`ifndef VMAD_PARAMS_SVH
`define VMAD_PARAMS_SVH
`define VMAD_CFG_RST 4'h0
`define VMAD_CFG_WIDE_BIT 3
`define VMAD_SEL_NONE 3'h7
`define VMAD_SEL_IRQ 3'h6
`define VMAD_SEL_TMR 3'h5
`define VMAD_SEL_PIO 3'h4
`define VMAD_SEL_JOY 3'h3
`define VMAD_SEL_SND 3'h2
`define VMAD_SEL_FDC 3'h1
`define VMAD_SEL_PRN 3'h0
`define VMAD_IO_IRQ 13'h004
`define VMAD_IO_TMR 13'h008
`define VMAD_IO_PIO 13'h00C
`define VMAD_IO_NMI 13'h014
`define VMAD_IO_SND 13'h018
`define VMAD_IO_JOY 13'h040
`define VMAD_IO_PRN 13'h06F
`define VMAD_IO_FDC 13'h07E
`define VMAD_IO_VID 12'h03D
`define VMAD_MEM_VID 5'h17
`define VMAD_MEM_ROM 4'hF
`endif

/* File: rtl/vmad_pkg.sv */
/*
 * types for the video memory map and address decode block.
 * assumes the params header is included by users for the numbers.
 */
package vmad_pkg;
    typedef struct packed {
        logic [19:0] addr;
        logic mem_io_qualifier;
        logic mem_rd_n;
        logic mem_wr_n;
        logic io_rd_n;
        logic io_wr_n;
    } vmad_cpu_t;
    typedef struct packed {
        logic high_res_clock_sel;
        logic high_res_addr_sel;
        logic graphics_select;
        logic four_colour_hires_sel;
        logic sixteen_colour_sel;
        logic new_video_mode_sel;
        logic extended_video_addr;
        logic video_addr_mode_hi;
        logic video_addr_mode_lo;
    } vmad_mode_t;
    typedef enum logic [2:0] {
        VMAD_ORG_16K_8P,
        VMAD_ORG_2X8K_8P,
        VMAD_ORG_2X16K_4P,
        VMAD_ORG_4X8K_4P,
        VMAD_ORG_32K_4P,
        VMAD_ORG_2X32K_2P
    } vmad_org_t;
endpackage

/* File: testbench/test_vmad_decode.sv */
/*
 * self-checking bench for vmad_decode: select codes, buffer enable, organisation.
 * assumes outputs follow the cpu bus three edges later and mode inputs one edge later.
 */
`timescale 1ns/1ps
module test_vmad_decode;
    import vmad_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    vmad_cpu_t cpu;
    vmad_mode_t mode = '0;
    logic [3:0] cfg = 4'h4;
    logic [2:0] page = 3'h0;
    logic [1:0] row = 2'h0;
    logic [13:0] chr = 14'h0;
    vmad_org_t org;
    logic [17:0] vaddr;
    logic [2:0] sel;
    logic buf_n;
    int err_total = 0;
    int check_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #2.5 ref_clk_i = ~ref_clk_i;
    vmad_cpu_model vmad_cpu_model_i (.ref_clk_i(ref_clk_i), .cpu_o(cpu));
    vmad_decode vmad_decode_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cpu_i(cpu),
        .mode_i(mode), .mem_cfg_i(cfg), .display_page_sel_i(page), .row_scan_addr_i(row),
        .char_addr_i(chr), .org_o(org), .video_addr_o(vaddr), .periph_sel_o(sel),
        .board_buffer_enable_n_o(buf_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus cycle; wait four edges to clear the two-stage synchroniser
    task automatic acc(input logic [19:0] a, input logic mem, input logic wr,
                       input logic [2:0] es, input logic eb);
        vmad_cpu_model_i.start(a, mem, wr);
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk("periph_sel", 20'(sel), 20'(es));
        chk("buffer_en_n", 20'(buf_n), 20'(eb));
        vmad_cpu_model_i.stop();
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk("sel_idle", 20'(sel), 20'h7);
    endtask
    task automatic t_reset();
        @(posedge ref_clk_i);
        #1;
        chk("rst_sel", 20'(sel), 20'h7);
        chk("rst_buf", 20'(buf_n), 20'h1);
        chk("rst_org", 20'(org), 20'(VMAD_ORG_16K_8P));
    endtask
    // window parked at 80000 so no i/o address falls inside it
    task automatic t_select();
        acc(20'h00020, 1'b0, 1'b0, 3'h6, 1'b1);
        acc(20'h00047, 1'b0, 1'b1, 3'h5, 1'b0);
        acc(20'h00060, 1'b0, 1'b0, 3'h4, 1'b0);
        acc(20'h00207, 1'b0, 1'b1, 3'h3, 1'b0);
        acc(20'h000C0, 1'b0, 1'b0, 3'h2, 1'b0);
        acc(20'h003F7, 1'b0, 1'b0, 3'h1, 1'b0);
        acc(20'h0037F, 1'b0, 1'b1, 3'h0, 1'b0);
        acc(20'h00028, 1'b0, 1'b0, 3'h7, 1'b1);
        acc(20'h00020, 1'b1, 1'b0, 3'h7, 1'b1);
        acc(20'h000A7, 1'b0, 1'b1, 3'h7, 1'b0);
        acc(20'h003D0, 1'b0, 1'b0, 3'h7, 1'b0);
        acc(20'h003DF, 1'b0, 1'b1, 3'h7, 1'b0);
        acc(20'h003E0, 1'b0, 1'b0, 3'h7, 1'b1);
    endtask
    // entry: config digit, five address digits, expected enable digit
    task automatic t_window();
        logic [27:0] w[16] = '{28'h01FFFF0, 28'h0200001, 28'h1200000, 28'h11FFFF1,
            28'h49FFFF0, 28'h47FFFF1, 28'h93FFFF0, 28'h9400001, 28'hC600000, 28'hC5FFFF1,
            28'h8000001, 28'h0B80000, 28'h0BFFFF0, 28'h0B7FFF1, 28'h0F00000, 28'h0EFFFF1};
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_i);
            cfg <= w[i][27:24];
            acc(w[i][23:4], 1'b1, 1'(i), 3'h7, w[i][0]);
        end
        @(posedge ref_clk_i);
        cfg <= 4'h4;
    endtask
    // mode bits: lo 0, hi 1, extended 2, graphics 6; the rest must not matter
    task automatic t_org();
        logic [8:0] md[9] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005,
            9'h040, 9'h042, 9'h1B8};
        logic [2:0] og[9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h3, 3'h0};
        // hand-packed: page on top, row segment bits, then character address
        logic [17:0] ev[9] = '{18'h00000, 18'h06111, 18'h10444, 18'h1C666, 18'h10888,
            18'h31554, 18'h18666, 18'h3CEEE, 18'h00888};
        for (int i = 0; i < 9; i++) begin
            @(posedge ref_clk_i);
            mode <= md[i];
            page <= 3'(i);
            row <= 2'(i);
            chr <= 14'(i * 14'h111);
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk("org", 20'(org), 20'(og[i]));
            chk("vaddr", 20'(vaddr), 20'(ev[i]));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_select();
        t_window();
        t_org();
        final_report();
    end
    // whole run needs about 2 us; generous margin for a hung handshake
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule

/* File: testbench/vmad_cpu_model.sv */
/*
 * cpu bus partner model: drives address, qualifier and strobes of vmad_cpu_t.
 * assumes the bench calls start and stop in turn, one bus cycle at a time.
 */
`timescale 1ns/1ps
module vmad_cpu_model (
    input wire logic ref_clk_i,
    output vmad_pkg::vmad_cpu_t cpu_o
);
    import vmad_pkg::*;
    // idle bus: memory qualifier, all strobes inactive high
    initial cpu_o = {20'h00000, 5'h1F};
    ////////////////////////////////////////////////////////////////////////////
    // one strobe low per cycle, held until stop so the synchroniser sees it
    task automatic start(input logic [19:0] a, input logic mem, input logic wr);
        @(posedge ref_clk_i);
        cpu_o.addr <= a;
        cpu_o.mem_io_qualifier <= mem;
        cpu_o.mem_rd_n <= !(mem && !wr);
        cpu_o.mem_wr_n <= !(mem && wr);
        cpu_o.io_rd_n <= !(!mem && !wr);
        cpu_o.io_wr_n <= !(!mem && wr);
    endtask
    // address left as is; strobes released and qualifier back to memory
    task automatic stop();
        @(posedge ref_clk_i);
        cpu_o <= {cpu_o.addr, 5'h1F};
    endtask
endmodule
